// ---- design/pm_regs_pkg.sv ----
`default_nettype none
package pm_regs_pkg;
  localparam logic [7:0]  RX_FIFO_LEVEL_INFO_OFS = 8'h7c;
  localparam logic [7:0]  TX_FIFO_LEVEL_INFO_OFS = 8'h80;
  localparam logic [7:0]  POWER_MGMT_CTRL_OFS    = 8'h84;
  localparam logic [7:0]  BYTE_TEST_OFS          = 8'h64;
  localparam int          STS_LSB                = 16;
  localparam int          STS_MSB                = 23;
  localparam int          PSEL_LSB               = 12;
  localparam int          PSEL_MSB               = 13;
  localparam int          XRST_BIT               = 10;
  localparam int          WOL_BIT                = 9;
  localparam int          ED_BIT                 = 8;
  localparam int          TYPE_BIT               = 6;
  localparam int          CAUSE_LSB              = 4;
  localparam int          CAUSE_MSB              = 5;
  localparam int          PULSE_BIT              = 3;
  localparam int          POL_BIT                = 2;
  localparam int          OUT_EN_BIT             = 1;
  localparam int          READY_BIT              = 0;
  localparam logic [15:0] TX_FREE_RESET          = 16'h1200;
  localparam logic [1:0]  FULL_POWER             = 2'h0;
  localparam logic [1:0]  WAKE_FRAME_SLEEP       = 2'h1;
  localparam logic [1:0]  ENERGY_SLEEP           = 2'h2;
  localparam logic [1:0]  CAUSE_ENERGY           = 2'h1;
  localparam logic [1:0]  CAUSE_WAKE             = 2'h2;
  localparam int          CLK_MHZ                = 200;
  localparam int          XRST_US                = 100;
  localparam int          PULSE_MS               = 50;
  localparam int          XRST_CYCLES            = XRST_US * CLK_MHZ;
  localparam int          PULSE_CYCLES           = PULSE_MS * 1000 * CLK_MHZ;
  localparam int          READY_CYCLES           = 16;
  // Host-side command registers on APB
  localparam logic [7:0]  H_ADDR_OFS   = 8'h00;
  localparam logic [7:0]  H_WDATA_OFS  = 8'h04;
  localparam logic [7:0]  H_CTRL_OFS   = 8'h08;
  localparam logic [7:0]  H_STATUS_OFS = 8'h0c;
  localparam logic [7:0]  H_RDATA_OFS  = 8'h10;
endpackage
`default_nettype wire

// ---- design/pm_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pm_link_if;
  logic        req;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;
  modport dev  (input req, wr, addr, wdata, output ack, rdata);
  modport host (output req, wr, addr, wdata, input ack, rdata);
endinterface
`default_nettype wire

// ---- design/pm_regs_dev.sv ----
// Added by the designer: the register device on the host link port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Rx status words used in bits 23-16
// - Rx data bytes used, word-rounded per frame
// - Tx status words used in bits 23-16
// - Tx free bytes in 15-0, reset 1200h
// - Host never overfills transmit data FIFO
// - Control register readable in every power state
// - Writes ignored until one read done
// - Power state field 13-12, self-clearing
// - Byte test write wakes from sleep
// - Not ready: host writes only byte test
// - Bit 10 resets transceiver at least 100us
// - Writes to bit 10 ignored while high
// - Lan wake event raises output and interrupt
// - Energy event raises output and interrupt
// - Bit 6 open-drain or push-pull type
// - Wake cause field records event type
// - Cause cleared by 1, full power, sources idle
// - Bit 3 pulses output 50ms, else level
// - Output drops when cause or enable clears
// - Bit 2 sets push-pull polarity
// - Bit 1 enables external event output
// - Bit 0 ready once stable after wake
module pm_regs_dev #(
  parameter int XRST_CYCLES  = pm_regs_pkg::XRST_CYCLES,
  parameter int PULSE_CYCLES = pm_regs_pkg::PULSE_CYCLES
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  pm_link_if.dev           bus,
  input  wire logic [7:0]  i_rx_status_words_used,
  input  wire logic [15:0] i_rx_data_bytes_used,
  input  wire logic [7:0]  i_tx_status_words_used,
  input  wire logic [15:0] i_tx_data_bytes_free,
  input  wire logic        i_lan_wake_event,
  input  wire logic        i_energy_event,
  output logic             o_transceiver_reset,
  output logic             o_power_event_interrupt,
  output logic             o_power_event_output,
  output logic             o_power_event_output_oe,
  output logic [1:0]       o_power_state
);
  logic [1:0]  power_state_select;
  logic        transceiver_reset;
  logic        lan_wake_enable;
  logic        energy_detect_enable;
  logic        event_output_buffer_type;
  logic [1:0]  wake_cause_status;
  logic        event_output_pulse_mode;
  logic        event_output_polarity;
  logic        event_output_enable;
  logic        ready;
  logic        read_seen;
  logic [31:0] xrst_cnt;
  logic [31:0] pulse_cnt;
  logic [4:0]  ready_cnt;
  logic        event_active;
  logic [1:0]  wake_s1;
  logic [1:0]  wake_s2;
  logic        wr_ok;
  logic        rd;
  logic        wr;
  logic        lan_hit;
  logic        energy_hit;
  logic [31:0] ctrl_word;
  logic [1:0]  clr;

  // Event pins arrive from outside; two flops before any use
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      wake_s1 <= 2'h0;
      wake_s2 <= 2'h0;
    end else begin
      wake_s1 <= {i_lan_wake_event, i_energy_event};
      wake_s2 <= wake_s1;
    end
  end

  assign rd         = bus.req && !bus.wr;
  assign wr         = bus.req && bus.wr;
  assign wr_ok      = wr && read_seen && ready;
  assign lan_hit    = wake_s2[1] && lan_wake_enable;
  assign energy_hit = wake_s2[0] && energy_detect_enable;
  assign bus.ack    = bus.req;

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[pm_regs_pkg::PSEL_MSB:pm_regs_pkg::PSEL_LSB] = power_state_select;
    ctrl_word[pm_regs_pkg::XRST_BIT]   = transceiver_reset;
    ctrl_word[pm_regs_pkg::WOL_BIT]    = lan_wake_enable;
    ctrl_word[pm_regs_pkg::ED_BIT]     = energy_detect_enable;
    ctrl_word[pm_regs_pkg::TYPE_BIT]   = event_output_buffer_type;
    ctrl_word[pm_regs_pkg::CAUSE_MSB:pm_regs_pkg::CAUSE_LSB] =
      wake_cause_status;
    ctrl_word[pm_regs_pkg::PULSE_BIT]  = event_output_pulse_mode;
    ctrl_word[pm_regs_pkg::POL_BIT]    = event_output_polarity;
    ctrl_word[pm_regs_pkg::OUT_EN_BIT] = event_output_enable;
    ctrl_word[pm_regs_pkg::READY_BIT]  = ready;
  end

  // Read data is registered; control readable in any state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      bus.rdata <= 32'h0;
    end else if (rd) begin
      unique case (bus.addr)
        pm_regs_pkg::RX_FIFO_LEVEL_INFO_OFS:
          bus.rdata <= {8'h0, i_rx_status_words_used,
                        i_rx_data_bytes_used};
        pm_regs_pkg::TX_FIFO_LEVEL_INFO_OFS:
          bus.rdata <= {8'h0, i_tx_status_words_used,
                        i_tx_data_bytes_free};
        pm_regs_pkg::POWER_MGMT_CTRL_OFS:
          bus.rdata <= ctrl_word;
        default:
          bus.rdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      read_seen <= 1'b0;
    end else if (rd) begin
      read_seen <= 1'b1;
    end else if (power_state_select != pm_regs_pkg::FULL_POWER) begin
      read_seen <= 1'b0;
    end
  end

  // Sleep entry and wake; ready comes back after a settling delay
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      power_state_select <= pm_regs_pkg::FULL_POWER;
      ready              <= 1'b0;
      ready_cnt          <= 5'h0;
    end else if (power_state_select != pm_regs_pkg::FULL_POWER) begin
      ready <= 1'b0;
      ready_cnt <= 5'h0;
      if ((wr && bus.addr == pm_regs_pkg::BYTE_TEST_OFS) || lan_hit ||
          energy_hit) begin
        power_state_select <= pm_regs_pkg::FULL_POWER;
      end
    end else if (!ready) begin
      ready_cnt <= ready_cnt + 5'h1;
      ready <= (ready_cnt == 5'(pm_regs_pkg::READY_CYCLES - 1));
    end else if (wr_ok && bus.addr == pm_regs_pkg::POWER_MGMT_CTRL_OFS) begin
      if (bus.wdata[pm_regs_pkg::PSEL_MSB:pm_regs_pkg::PSEL_LSB] ==
          pm_regs_pkg::WAKE_FRAME_SLEEP ||
          bus.wdata[pm_regs_pkg::PSEL_MSB:pm_regs_pkg::PSEL_LSB] ==
          pm_regs_pkg::ENERGY_SLEEP) begin
        power_state_select <=
          bus.wdata[pm_regs_pkg::PSEL_MSB:pm_regs_pkg::PSEL_LSB];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      lan_wake_enable          <= 1'b0;
      energy_detect_enable     <= 1'b0;
      event_output_buffer_type <= 1'b0;
      event_output_pulse_mode  <= 1'b0;
      event_output_polarity    <= 1'b0;
      event_output_enable      <= 1'b0;
    end else if (wr_ok && bus.addr == pm_regs_pkg::POWER_MGMT_CTRL_OFS) begin
      lan_wake_enable          <= bus.wdata[pm_regs_pkg::WOL_BIT];
      energy_detect_enable     <= bus.wdata[pm_regs_pkg::ED_BIT];
      event_output_buffer_type <= bus.wdata[pm_regs_pkg::TYPE_BIT];
      event_output_pulse_mode  <= bus.wdata[pm_regs_pkg::PULSE_BIT];
      event_output_polarity    <= bus.wdata[pm_regs_pkg::POL_BIT];
      event_output_enable      <= bus.wdata[pm_regs_pkg::OUT_EN_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      transceiver_reset <= 1'b0;
      xrst_cnt          <= 32'h0;
    end else if (transceiver_reset) begin
      xrst_cnt <= xrst_cnt + 32'h1;
      if (xrst_cnt == 32'(XRST_CYCLES - 1)) begin
        transceiver_reset <= 1'b0;
      end
    end else if (wr_ok && bus.addr == pm_regs_pkg::POWER_MGMT_CTRL_OFS &&
                 bus.wdata[pm_regs_pkg::XRST_BIT]) begin
      transceiver_reset <= 1'b1;
      xrst_cnt          <= 32'h0;
    end
  end

  // Clear needs full power, ready, and the source gone; a set wins
  always_comb begin
    clr = 2'h0;
    if (wr_ok && bus.addr == pm_regs_pkg::POWER_MGMT_CTRL_OFS &&
        power_state_select == pm_regs_pkg::FULL_POWER) begin
      clr = bus.wdata[pm_regs_pkg::CAUSE_MSB:pm_regs_pkg::CAUSE_LSB] &
            ~wake_s2;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      wake_cause_status <= 2'h0;
    end else begin
      wake_cause_status <= (wake_cause_status & ~clr) |
        (lan_hit ? pm_regs_pkg::CAUSE_WAKE : 2'h0) |
        (energy_hit ? pm_regs_pkg::CAUSE_ENERGY : 2'h0);
    end
  end

  assign event_active = (wake_cause_status[1] && lan_wake_enable) ||
                        (wake_cause_status[0] && energy_detect_enable);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pulse_cnt <= 32'h0;
    end else if (!event_active) begin
      pulse_cnt <= 32'h0;
    end else if (pulse_cnt != 32'(PULSE_CYCLES)) begin
      pulse_cnt <= pulse_cnt + 32'h1;
    end
  end

  logic asserted;
  assign asserted = event_output_enable && event_active &&
    (!event_output_pulse_mode || pulse_cnt != 32'(PULSE_CYCLES));

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_power_event_output    <= 1'b0;
      o_power_event_output_oe <= 1'b0;
    end else if (event_output_buffer_type) begin
      o_power_event_output    <= asserted ~^ event_output_polarity;
      o_power_event_output_oe <= 1'b1;
    end else begin
      o_power_event_output    <= 1'b0;
      o_power_event_output_oe <= asserted;
    end
  end

  assign o_power_event_interrupt = |wake_cause_status;
  assign o_transceiver_reset     = transceiver_reset;
  assign o_power_state           = power_state_select;
endmodule
`default_nettype wire

// ---- design/pm_regs_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host end: APB commands become link transfers
module pm_regs_host (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  pm_link_if.host          link
);
  typedef enum logic [1:0] {IDLE = 2'b01, BUSY = 2'b10} hstate_e;
  hstate_e     state;
  logic [7:0]  cmd_addr;
  logic [31:0] cmd_wdata;
  logic [31:0] rdata;
  logic        done;
  logic        apb_wr;
  logic        go;

  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign go = apb_wr && i_paddr == pm_regs_pkg::H_CTRL_OFS &&
              state == IDLE;
  assign o_pready  = i_psel && i_penable;
  assign o_pslverr = 1'b0;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      cmd_addr  <= 8'h0;
      cmd_wdata <= 32'h0;
    end else if (apb_wr && i_paddr == pm_regs_pkg::H_ADDR_OFS) begin
      cmd_addr <= i_pwdata[7:0];
    end else if (apb_wr && i_paddr == pm_regs_pkg::H_WDATA_OFS) begin
      cmd_wdata <= i_pwdata;
    end
  end

  // Software must start with a read and, while not ready, only
  // write the byte test address; this end does not police it.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state      <= IDLE;
      link.req   <= 1'b0;
      link.wr    <= 1'b0;
      link.addr  <= 8'h0;
      link.wdata <= 32'h0;
      rdata      <= 32'h0;
      done       <= 1'b0;
    end else begin
      unique case (state)
        IDLE: begin
          if (go) begin
            link.req   <= 1'b1;
            link.wr    <= i_pwdata[0];
            link.addr  <= cmd_addr;
            link.wdata <= cmd_wdata;
            done       <= 1'b0;
            state      <= BUSY;
          end
        end
        BUSY: begin
          if (link.ack) begin
            link.req <= 1'b0;
            state    <= IDLE;
            done     <= 1'b1;
          end
        end
        default: state <= IDLE;
      endcase
      if (state == IDLE && !link.req && done && !link.wr) begin
        rdata <= link.rdata;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      unique case (i_paddr)
        pm_regs_pkg::H_ADDR_OFS:   o_prdata <= {24'h0, cmd_addr};
        pm_regs_pkg::H_WDATA_OFS:  o_prdata <= cmd_wdata;
        pm_regs_pkg::H_STATUS_OFS: o_prdata <= {30'h0, done,
                                                state == BUSY};
        pm_regs_pkg::H_RDATA_OFS:  o_prdata <= rdata;
        default:                   o_prdata <= 32'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verif/pm_link_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module pm_link_monitor #(
  parameter int XRST_CYCLES = pm_regs_pkg::XRST_CYCLES
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  input  wire logic        o_transceiver_reset,
  input  wire logic [1:0]  o_power_state
);
  logic [7:0]  up_cnt;
  logic [31:0] hi_cnt;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) up_cnt <= 8'h00;
    else if (up_cnt != 8'hff) up_cnt <= up_cnt + 8'h01;
  end
  // Holds the length of the last high stretch in the cycle after it ends
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !o_transceiver_reset) hi_cnt <= 32'h0;
    else hi_cnt <= hi_cnt + 32'h1;
  end
  sequence s_rd_ctrl;
    req && !wr && addr == pm_regs_pkg::POWER_MGMT_CTRL_OFS;
  endsequence
  sequence s_wake;
    o_power_state != 2'h0 ##0 req && wr &&
      addr == pm_regs_pkg::BYTE_TEST_OFS;
  endsequence
  a_ack_same_cycle: assert property (ack == req)
    else $error("link ack does not follow req");
  a_req_spacing: assert property (req |=> !req)
    else $error("link requests closer than two cycles");
  a_rdata_holds: assert property (!(req && !wr) |=> $stable(rdata))
    else $error("read data moved without a read");
  a_ctrl_reserved: assert property (s_rd_ctrl |=>
    rdata[31:14] == 18'h0 && !rdata[11] && !rdata[7])
    else $error("reserved control bits read nonzero");
  a_fifo_reserved: assert property (req && !wr &&
    (addr == pm_regs_pkg::RX_FIFO_LEVEL_INFO_OFS ||
     addr == pm_regs_pkg::TX_FIFO_LEVEL_INFO_OFS) |=> rdata[31:24] == 8'h00)
    else $error("reserved level bits read nonzero");
  a_no_state_three: assert property (o_power_state != 2'h3)
    else $error("reserved power state entered");
  a_reserved_state: assert property (req && wr &&
    addr == pm_regs_pkg::POWER_MGMT_CTRL_OFS &&
    wdata[pm_regs_pkg::PSEL_MSB:pm_regs_pkg::PSEL_LSB] == 2'h3 |=>
    $stable(o_power_state))
    else $error("reserved power state write took effect");
  a_byte_test_wake: assert property (s_wake |-> ##[1:8]
    o_power_state == 2'h0)
    else $error("byte test write did not wake");
  a_xrst_hold: assert property ($fell(o_transceiver_reset) |->
    hi_cnt == 32'(XRST_CYCLES))
    else $error("transceiver reset too short");
  a_ready_late: assert property (s_rd_ctrl ##0 up_cnt < 8'h0e |=>
    !rdata[0])
    else $error("ready read high too early");
endmodule
`default_nettype wire

// ---- verif/tb_fifo_level_and_power_mgmt_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_fifo_level_and_power_mgmt_regs;
  localparam int XR = 200;
  localparam int PL = 60;
  logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, lan_ev = 1'b0, en_ev = 1'b0;
  logic [7:0]  paddr = 8'h00, rx_sw = 8'h00, tx_sw = 8'h00;
  logic [15:0] rx_db = 16'h0000, tx_df = 16'h1200;
  logic [31:0] pwdata = 32'h0, seed = 32'hf, q;
  logic        pready, pslverr, xrst, pint, pout, poe;
  logic [31:0] prdata;
  logic [1:0]  pstate;
  int          failures = 0, check_count = 0;
  pm_link_if pm_link_if_inst ();
  pm_regs_host pm_regs_host_inst (.i_mclk(mclk), .i_rst_b(rst_b),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .link(pm_link_if_inst));
  pm_regs_dev #(.XRST_CYCLES(XR), .PULSE_CYCLES(PL)) pm_regs_dev_inst (
    .i_mclk(mclk), .i_rst_b(rst_b), .bus(pm_link_if_inst),
    .i_rx_status_words_used(rx_sw), .i_rx_data_bytes_used(rx_db),
    .i_tx_status_words_used(tx_sw), .i_tx_data_bytes_free(tx_df),
    .i_lan_wake_event(lan_ev), .i_energy_event(en_ev),
    .o_transceiver_reset(xrst), .o_power_event_interrupt(pint),
    .o_power_event_output(pout), .o_power_event_output_oe(poe),
    .o_power_state(pstate));
  pm_link_monitor #(.XRST_CYCLES(XR)) pm_link_monitor_inst (.i_mclk(mclk),
    .i_rst_b(rst_b), .req(pm_link_if_inst.req), .wr(pm_link_if_inst.wr),
    .addr(pm_link_if_inst.addr), .wdata(pm_link_if_inst.wdata),
    .ack(pm_link_if_inst.ack), .rdata(pm_link_if_inst.rdata),
    .o_transceiver_reset(xrst), .o_power_state(pstate));
  always #2.5 mclk = ~mclk;
  task test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // One device access through the host command registers
  task lk(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    apb(1'b1, pm_regs_pkg::H_ADDR_OFS, {24'h0, a});
    apb(1'b1, pm_regs_pkg::H_WDATA_OFS, d);
    apb(1'b1, pm_regs_pkg::H_CTRL_OFS, {31'h0, w});
    n = 0;
    do begin
      apb(1'b0, pm_regs_pkg::H_STATUS_OFS, 32'h0);
      n++;
    end while (q[1] !== 1'b1 && n < 40);
    if (q[1] !== 1'b1) begin
      failures++;
      $display("mismatch link done expected 1 seen %b", q[1]);
    end
    apb(1'b0, pm_regs_pkg::H_STATUS_OFS, 32'h0);
    apb(1'b0, pm_regs_pkg::H_RDATA_OFS, 32'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    lk(1'b0, a, 32'h0);
    chk_reg(nm, e, q);
  endtask
  task rc(input logic [31:0] e, input string nm);
    rd(pm_regs_pkg::POWER_MGMT_CTRL_OFS, e, nm);
  endtask
  task wc(input logic [31:0] d);
    lk(1'b1, pm_regs_pkg::POWER_MGMT_CTRL_OFS, d);
  endtask
  task rst_seq;
    rst_b <= 1'b0;
    cyc(6);
    rst_b <= 1'b1;
    @(posedge mclk);
  endtask
  initial begin
    logic [31:0] r;
    int n;
    rst_seq();
    lk(1'b0, pm_regs_pkg::POWER_MGMT_CTRL_OFS, 32'h0);
    rst_seq();
    wc(32'h300);
    rc(32'h1, "ctrl after reset");
    wc(32'hffffb8ce);
    rc(32'h4f, "ctrl reserved");
    rd(pm_regs_pkg::TX_FIFO_LEVEL_INFO_OFS, 32'h1200, "tx reset");
    for (int i = 0; i < 4; i++) begin
      r = xs();
      rx_sw <= r[7:0];
      rx_db <= r[23:8];
      tx_sw <= r[31:24];
      tx_df <= r[15:0];
      rd(pm_regs_pkg::RX_FIFO_LEVEL_INFO_OFS,
         {8'h0, r[7:0], r[23:8]}, "rx");
      rd(pm_regs_pkg::TX_FIFO_LEVEL_INFO_OFS,
         {8'h0, r[31:24], r[15:0]}, "tx");
    end
    $display("test levels done");
    wc(32'h44e);
    chk_pin("xrst on", 16'h1, {15'h0, xrst});
    // A second set while high must not restart the hold time
    wc(32'h44e);
    rc(32'h44f, "xrst held");
    cyc(XR);
    rc(32'h4f, "xrst done");
    $display("test transceiver reset done");
    // Level mode, so with the enables kept set only the cause clear can drop the output
    wc(32'h246);
    lan_ev <= 1'b1;
    cyc(8);
    chk_pin("event out level", 16'h1, {15'h0, pout});
    chk_pin("event int", 16'h1, {15'h0, pint});
    wc(32'h266);
    rc(32'h267, "cause held");
    chk_pin("event out held", 16'h1, {15'h0, pout});
    lan_ev <= 1'b0;
    cyc(4);
    wc(32'h266);
    rc(32'h247, "cause clear");
    chk_pin("event out off", 16'h0, {15'h0, pout});
    $display("test lan wake done");
    wc(32'h14e);
    en_ev <= 1'b1;
    n = 0;
    while (pout !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    en_ev <= 1'b0;
    n = 0;
    while (pout === 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk_pin("pulse len", PL[15:0], n[15:0]);
    rc(32'h15f, "energy cause");
    wc(32'h106);
    en_ev <= 1'b1;
    cyc(6);
    en_ev <= 1'b0;
    chk_pin("od oe", 16'h1, {15'h0, poe});
    chk_pin("od low", 16'h0, {15'h0, pout});
    wc(32'h104);
    chk_pin("oe off", 16'h0, {15'h0, poe});
    chk_pin("int kept", 16'h1, {15'h0, pint});
    cyc(4);
    wc(32'h134);
    chk_pin("int clear", 16'h0, {15'h0, pint});
    $display("test energy done");
    for (int s = 1; s < 3; s++) begin
      wc(32'h104 | (s << 12));
      chk_pin("sleep", s[15:0], {14'h0, pstate});
      lk(1'b1, pm_regs_pkg::BYTE_TEST_OFS, xs());
      chk_pin("awake", 16'h0, {14'h0, pstate});
      cyc(20);
      // No read since the wake, so this write must be dropped
      wc(32'h106);
      rc(32'h105, "after wake");
    end
    $display("test sleep done");
    test_done();
  end
  initial begin
    cyc(30000);
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
